// ==== hdl/lamsr_top.sv ====
// Overview of operation
// RL1: fault byte holds thermal, short, open, undervoltage and overcurrent in bits 4..0, top three bits zero.
// RL2: all fault flags clear when the device goes from standby to active.
// RL3: a thermal trip forces standby and active is refused while the thermal flag or condition stands.
// RL4: settle bit 0 gives two resonance periods, 1 gives one.
// RL5: output-type bit 0 selects switched drive, 1 selects linear drive.
// RL6: rate field decodes 000 0.5, 001 1, 011 2, 101 4.8, 110 6.0, 111 4 MHz, 010 and 100 unassigned.
// RL7: the host writes the resonance code as 383 minus 19200 over the resonance in hertz, rounded.
// RL8: the resonance code resets to 8'h83, a 76.2 Hz default.
// RL9: the resonance code covers tuning from 50 Hz to 150 Hz.
// RL10: the mode byte resets to zero and its top three bits read zero.
// RL11: a software reset restores all registers, enters standby and self-clears.
// RL12: a new coil current applies only when the low byte write completes.
// RL13: mode byte holds rate in bits 4..2, output type in bit 1, settle in bit 0.
// RL14: writes to the fault byte and unused mode bits are ignored.
`include "lamsr_map.svh"
`timescale 1ns/10ps
`default_nettype none
module lamsr_top (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire lamsr_pkg::lamsr_req_t req_in,
  output logic [7:0] rdata_out,
  input wire logic go_active_in,
  input wire logic go_standby_in,
  input wire lamsr_pkg::lamsr_faults_t fault_det_in,
  input wire logic die_hot_in,
  output logic active_out,
  output logic linear_mode_out,
  output lamsr_pkg::lamsr_rate_t switch_rate_sel_out,
  output lamsr_pkg::lamsr_rate_info_t rate_info_out,
  output logic one_period_settle_out,
  output logic ring_en_out,
  output logic [7:0] resonance_code_out,
  output logic [9:0] coil_current_code_out,
  output logic coil_current_load_out
);
  import lamsr_pkg::*;

  lamsr_regs_t r;
  lamsr_regs_t next_r;
  logic load_r;
  logic next_load;
  logic [5:0] det_sync;
  lamsr_faults_t det;
  logic hot_sync;
  logic wr_ctrl;
  logic soft_rst;

  function automatic lamsr_regs_t defaults(input logic [7:0] rd);
    lamsr_regs_t d;
    d.st = LAMSR_ST_STANDBY;
    d.fault_flags = `LAMSR_RST_FAULT;
    d.drive_mode_config = `LAMSR_RST_MODE; // [RL10]
    d.coil_resonance_code = `LAMSR_RST_RES; // [RL8]
    d.ring_en = `LAMSR_RST_RING_EN;
    d.cur_hi = 2'h0;
    d.coil_current_code = `LAMSR_RST_CUR;
    d.rdata = rd;
    return d;
  endfunction

  function automatic logic hit(input lamsr_req_t q, input logic [7:0] a);
    return q.wr && (q.addr == a);
  endfunction

  lamsr_sync #(
    .WIDTH(6)
  ) u_sync (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .async_in({die_hot_in, fault_det_in}),
    .sync_out(det_sync)
  );
  assign det = det_sync[4:0];
  assign hot_sync = det_sync[5];

  lamsr_rate_dec u_rate (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .rate_in(switch_rate_sel_out),
    .info_out(rate_info_out)
  );

  assign wr_ctrl = hit(req_in, `LAMSR_ADDR_CTRL);
  assign soft_rst = wr_ctrl && req_in.wdata[`LAMSR_CTRL_BIT_RST]; // [RL11]

  always_comb
  begin
    next_r = r;
    next_load = 1'b0;
    // sticky fault capture
    next_r.fault_flags = (r.fault_flags | {3'h0, det}) & `LAMSR_FAULT_MASK; // [RL1]
    case (r.st)
      LAMSR_ST_STANDBY:
      begin
        // thermal trip blocks wake until cooled and flag cleared
        if (go_active_in && !r.fault_flags[`LAMSR_BIT_TSD] && !det.thermal_trip_flag && !hot_sync) // [RL3]
        begin
          next_r.st = LAMSR_ST_ACTIVE;
          next_r.fault_flags = {3'h0, det}; // [RL2]
        end
      end
      LAMSR_ST_ACTIVE:
      begin
        if (go_standby_in || det.thermal_trip_flag) // [RL3]
          next_r.st = LAMSR_ST_STANDBY;
      end
      default:
        next_r.st = LAMSR_ST_STANDBY;
    endcase
    // cooled die in standby releases the thermal flag
    if (r.st == LAMSR_ST_STANDBY && !hot_sync && !det.thermal_trip_flag)
      next_r.fault_flags[`LAMSR_BIT_TSD] = 1'b0; // [RL3]
    if (wr_ctrl)
      next_r.ring_en = req_in.wdata[`LAMSR_CTRL_BIT_RING];
    if (hit(req_in, `LAMSR_ADDR_CUR_HI))
      next_r.cur_hi = req_in.wdata[1:0];
    if (hit(req_in, `LAMSR_ADDR_CUR_LO))
    begin
      next_r.coil_current_code = {r.cur_hi, req_in.wdata}; // [RL12]
      next_load = 1'b1;
    end
    // fault byte has no write path
    if (hit(req_in, `LAMSR_ADDR_MODE))
      next_r.drive_mode_config = req_in.wdata & `LAMSR_MODE_MASK; // [RL14] [RL13]
    if (hit(req_in, `LAMSR_ADDR_RES))
      next_r.coil_resonance_code = req_in.wdata; // [RL9]
    if (soft_rst)
    begin
      next_r = defaults(r.rdata); // [RL11]
      next_r.fault_flags = {3'h0, det};
      next_load = 1'b1;
    end
    next_r.rdata = 8'h00;
    if (req_in.rd)
    begin
      case (req_in.addr)
        `LAMSR_ADDR_CTRL: next_r.rdata = {6'h00, r.ring_en, 1'b0};
        `LAMSR_ADDR_CUR_HI: next_r.rdata = {6'h00, r.coil_current_code[9:8]};
        `LAMSR_ADDR_CUR_LO: next_r.rdata = r.coil_current_code[7:0];
        `LAMSR_ADDR_FAULT: next_r.rdata = r.fault_flags & `LAMSR_FAULT_MASK; // [RL1]
        `LAMSR_ADDR_MODE: next_r.rdata = r.drive_mode_config & `LAMSR_MODE_MASK; // [RL10]
        `LAMSR_ADDR_RES: next_r.rdata = r.coil_resonance_code;
        default: next_r.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      r <= defaults(8'h00);
      load_r <= 1'b0;
    end
    else
    begin
      r <= next_r;
      load_r <= next_load;
    end
  end

  assign rdata_out = r.rdata;
  assign active_out = (r.st == LAMSR_ST_ACTIVE);
  assign linear_mode_out = r.drive_mode_config[`LAMSR_BIT_LIN]; // [RL5]
  assign switch_rate_sel_out = lamsr_rate_t'(r.drive_mode_config[`LAMSR_RATE_MSB:`LAMSR_RATE_LSB]); // [RL13]
  assign one_period_settle_out = r.drive_mode_config[`LAMSR_BIT_SETTLE]; // [RL4]
  assign ring_en_out = r.ring_en;
  assign resonance_code_out = r.coil_resonance_code;
  assign coil_current_code_out = r.coil_current_code;
  assign coil_current_load_out = load_r;
endmodule
`default_nettype wire

// ==== hdl/lamsr_map.svh ====
`ifndef LAMSR_MAP_SVH
`define LAMSR_MAP_SVH
`define LAMSR_ADDR_CTRL 8'h02
`define LAMSR_ADDR_CUR_HI 8'h03
`define LAMSR_ADDR_CUR_LO 8'h04
`define LAMSR_ADDR_FAULT 8'h05
`define LAMSR_ADDR_MODE 8'h06
`define LAMSR_ADDR_RES 8'h07
`define LAMSR_RST_FAULT 8'h00
`define LAMSR_RST_MODE 8'h00
`define LAMSR_RST_RES 8'h83
`define LAMSR_RST_CUR 10'h000
`define LAMSR_RST_RING_EN 1'b1
`define LAMSR_MODE_MASK 8'h1f
`define LAMSR_FAULT_MASK 8'h1f
`define LAMSR_BIT_TSD 4
`define LAMSR_BIT_SHORT 3
`define LAMSR_BIT_OPEN 2
`define LAMSR_BIT_UV 1
`define LAMSR_BIT_OVC 0
`define LAMSR_RATE_MSB 4
`define LAMSR_RATE_LSB 2
`define LAMSR_BIT_LIN 1
`define LAMSR_BIT_SETTLE 0
`define LAMSR_CTRL_BIT_RST 0
`define LAMSR_CTRL_BIT_RING 1
`define LAMSR_RES_MIN 8'h00
`define LAMSR_RES_MAX 8'hff
`endif

// ==== hdl/lamsr_pkg.sv ====
package lamsr_pkg;
  typedef struct packed {
    logic thermal_trip_flag;
    logic coil_short_flag;
    logic coil_open_flag;
    logic undervoltage_flag;
    logic overcurrent_flag;
  } lamsr_faults_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lamsr_req_t;

  typedef enum logic [2:0] {
    LAMSR_RATE_0M5 = 3'h0,
    LAMSR_RATE_1M0 = 3'h1,
    LAMSR_RATE_NA2 = 3'h2,
    LAMSR_RATE_2M0 = 3'h3,
    LAMSR_RATE_NA4 = 3'h4,
    LAMSR_RATE_4M8 = 3'h5,
    LAMSR_RATE_6M0 = 3'h6,
    LAMSR_RATE_4M0 = 3'h7
  } lamsr_rate_t;

  typedef struct packed {
    logic valid;
    logic [12:0] khz;
  } lamsr_rate_info_t;

  typedef enum logic [1:0] {
    LAMSR_ST_STANDBY = 2'b01,
    LAMSR_ST_ACTIVE = 2'b10
  } lamsr_state_t;

  typedef struct packed {
    lamsr_state_t st;
    logic [7:0] fault_flags;
    logic [7:0] drive_mode_config;
    logic [7:0] coil_resonance_code;
    logic ring_en;
    logic [1:0] cur_hi;
    logic [9:0] coil_current_code;
    logic [7:0] rdata;
  } lamsr_regs_t;
endpackage

// ==== hdl/lamsr_sync.sv ====
`timescale 1ns/10ps
`default_nettype none
// two-stage synchroniser for fault detector levels
module lamsr_sync #(
  parameter int WIDTH = 5
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } lamsr_sync_st_t;
  lamsr_sync_st_t r;
  lamsr_sync_st_t next_r;
  always_comb
  begin
    next_r.s1 = async_in;
    next_r.s2 = r.s1;
  end
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
      r <= '0;
    else
      r <= next_r;
  end
  assign sync_out = r.s2;
endmodule
`default_nettype wire

// ==== hdl/lamsr_rate_dec.sv ====
`timescale 1ns/10ps
`default_nettype none
// decodes switching-rate field into kHz and a valid flag
module lamsr_rate_dec (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire lamsr_pkg::lamsr_rate_t rate_in,
  output lamsr_pkg::lamsr_rate_info_t info_out
);
  import lamsr_pkg::*;
  typedef struct packed {
    lamsr_rate_info_t info;
  } lamsr_rd_st_t;
  lamsr_rd_st_t r;
  lamsr_rd_st_t next_r;

  function automatic lamsr_rate_info_t decode(input lamsr_rate_t c);
    lamsr_rate_info_t d;
    d.valid = 1'b1;
    case (c)
      LAMSR_RATE_0M5: d.khz = 13'd500;
      LAMSR_RATE_1M0: d.khz = 13'd1000;
      LAMSR_RATE_2M0: d.khz = 13'd2000;
      LAMSR_RATE_4M8: d.khz = 13'd4800;
      LAMSR_RATE_6M0: d.khz = 13'd6000;
      LAMSR_RATE_4M0: d.khz = 13'd4000;
      default:
      begin
        d.valid = 1'b0;
        d.khz = 13'd0;
      end
    endcase
    return d;
  endfunction

  always_comb
  begin
    next_r.info = decode(rate_in); // [RL6]
  end
  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
      r <= '{info: '{valid: 1'b1, khz: 13'd500}};
    else
      r <= next_r;
  end
  assign info_out = r.info;
endmodule
`default_nettype wire

// ==== test/lamsr_chk.sv ====
`timescale 1ns/10ps
`default_nettype none
module lamsr_chk
  import lamsr_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire lamsr_pkg::lamsr_req_t req_in,
  input wire logic [7:0] rdata_out,
  input wire logic active_out,
  input wire logic linear_mode_out,
  input wire lamsr_pkg::lamsr_rate_t switch_rate_sel_out,
  input wire lamsr_pkg::lamsr_rate_info_t rate_info_out,
  input wire logic one_period_settle_out,
  input wire logic ring_en_out,
  input wire logic [7:0] resonance_code_out,
  input wire logic [9:0] coil_current_code_out,
  input wire logic coil_current_load_out,
  input wire lamsr_pkg::lamsr_faults_t fault_det_in,
  input wire logic die_hot_in
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  a_fault_top_zero: assert property (req_in.rd && req_in.addr == 8'h05 |=> rdata_out[7:5] == 3'h0)
    else $error("fault byte top bits set");
  a_mode_read_back: assert property (req_in.rd && req_in.addr == 8'h06 |=> rdata_out ==
    {3'h0, $past(switch_rate_sel_out), $past(linear_mode_out), $past(one_period_settle_out)})
    else $error("mode read differs from outputs");
  a_reset_values: assert property ($rose(rst_n_in) |-> !active_out && resonance_code_out == 8'h83
    && {switch_rate_sel_out, linear_mode_out, one_period_settle_out} == 5'h00 && ring_en_out)
    else $error("bad reset values");
  a_thermal_standby: assert property (active_out && fault_det_in.thermal_trip_flag |-> ##[1:6] !active_out)
    else $error("thermal trip kept device active");
  a_hot_no_wake: assert property ((!active_out && die_hot_in)[*4] |=> !active_out)
    else $error("woke while die hot");
  a_low_byte_load: assert property (req_in.wr && req_in.addr == 8'h04 |=> coil_current_load_out
    && coil_current_code_out[7:0] == $past(req_in.wdata))
    else $error("current not applied after low byte");
  a_soft_reset: assert property (req_in.wr && req_in.addr == 8'h02 && req_in.wdata[0]
    |=> !active_out && resonance_code_out == 8'h83 && ring_en_out)
    else $error("soft reset incomplete");
  a_rate_valid: assert property (rate_info_out.valid ==
    !($past(switch_rate_sel_out) inside {LAMSR_RATE_NA2, LAMSR_RATE_NA4}))
    else $error("rate valid flag wrong");
endmodule
`default_nettype wire

// ==== test/lamsr_host.sv ====
`timescale 1ns/10ps
`default_nettype none
module lamsr_host (
  input wire logic mclk_in,
  output lamsr_pkg::lamsr_req_t req_out
);
  import lamsr_pkg::*;
  initial req_out = '0;
  // one register access, held for exactly the taking edge
  task automatic acc(input logic w, input logic [7:0] a, d);
    @(posedge mclk_in);
    req_out <= '{w, !w, a, d};
    @(posedge mclk_in);
    req_out <= '0;
  endtask
  // resonance code rounded to nearest
  function automatic logic [7:0] res_code(input int hz);
    return 8'(383 - (38400 / hz + 1) / 2);
  endfunction
endmodule
`default_nettype wire

// ==== test/tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb;
  import lamsr_pkg::*;
  logic mclk_in = 0;
  logic rst_n_in = 0;
  logic go_a = 0;
  logic go_s = 0;
  logic hot = 0;
  lamsr_faults_t flt = '0;
  lamsr_req_t req;
  logic [7:0] rdat;
  logic act, lin, ops;
  lamsr_rate_t rate;
  lamsr_rate_info_t ri;
  logic [7:0] res;
  logic [9:0] cur;
  int mismatches = 0;
  int num_checks = 0;
  always #20 mclk_in = ~mclk_in;
  lamsr_host host (.mclk_in(mclk_in), .req_out(req));
  lamsr_top uut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .req_in(req), .rdata_out(rdat),
    .go_active_in(go_a), .go_standby_in(go_s), .fault_det_in(flt), .die_hot_in(hot),
    .active_out(act), .linear_mode_out(lin), .switch_rate_sel_out(rate), .rate_info_out(ri),
    .one_period_settle_out(ops), .ring_en_out(), .resonance_code_out(res),
    .coil_current_code_out(cur), .coil_current_load_out());
  task automatic chk(input logic [15:0] got, exp, input string m);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  task automatic rd(input logic [7:0] a, exp);
    host.acc(0, a, 8'h00);
    #1 chk(rdat, exp, "read");
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_in);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic t_reset;
    rd(8'h05, 8'h00);
    rd(8'h06, 8'h00);
    rd(8'h07, 8'h83);
    rd(8'h08, 8'h00);
    $display("t_reset done");
  endtask
  task automatic t_mode;
    int khz[8] = '{500, 1000, 0, 2000, 0, 4800, 6000, 4000};
    logic [7:0] m;
    for (int i = 0; i < 8; i++)
    begin
      m = {3'h7, i[2:0], i[0], !i[0]};
      host.acc(1, 8'h06, m);
      rd(8'h06, {3'h0, m[4:0]});
      chk(rate, i[2:0], "rate");
      chk(lin, i[0], "output type");
      chk(ops, !i[0], "settle");
      chk({ri.valid, ri.khz}, {khz[i] != 0, 13'(khz[i])}, "decode");
    end
    $display("t_mode done");
  endtask
  task automatic t_res;
    host.acc(1, 8'h07, host.res_code(100));
    rd(8'h07, 8'hbf);
    chk(res, 8'hbf, "code out");
    host.acc(1, 8'h07, host.res_code(150));
    rd(8'h07, 8'hff);
    $display("t_res done");
  endtask
  task automatic t_fault;
    @(posedge mclk_in);
    flt <= 5'h1f;
    cyc(5);
    rd(8'h05, 8'h1f);
    host.acc(1, 8'h05, 8'h00);
    rd(8'h05, 8'h1f);
    @(posedge mclk_in);
    flt <= '0;
    cyc(6);
    rd(8'h05, 8'h0f);
    @(posedge mclk_in);
    go_a <= 1;
    cyc(4);
    go_a <= 0;
    cyc(2);
    chk(act, 1'b1, "active");
    rd(8'h05, 8'h00);
    @(posedge mclk_in);
    flt <= 5'h10;
    cyc(8);
    chk(act, 1'b0, "thermal standby");
    hot <= 1;
    flt <= '0;
    go_a <= 1;
    cyc(12);
    chk(act, 1'b0, "hot refusal");
    hot <= 0;
    cyc(8);
    chk(act, 1'b1, "cooled wake");
    go_a <= 0;
    rd(8'h05, 8'h00);
    // plain standby request, then wake again for the soft reset test
    @(posedge mclk_in);
    go_s <= 1;
    cyc(2);
    chk(act, 1'b0, "standby request");
    go_s <= 0;
    go_a <= 1;
    cyc(2);
    go_a <= 0;
    chk(act, 1'b1, "rewake");
    $display("t_fault done");
  endtask
  task automatic t_soft;
    host.acc(1, 8'h03, 8'h02);
    #1 chk(cur, 10'h000, "early apply");
    host.acc(1, 8'h04, 8'h5a);
    #1 chk(cur, 10'h25a, "current");
    host.acc(1, 8'h06, 8'h15);
    host.acc(1, 8'h02, 8'h01);
    #1 chk({act, cur}, 11'h000, "soft reset");
    rd(8'h02, 8'h02);
    rd(8'h06, 8'h00);
    rd(8'h07, 8'h83);
    $display("t_soft done");
  endtask
  initial
  begin
    cyc(5);
    rst_n_in <= 1;
    t_reset;
    t_mode;
    t_res;
    t_fault;
    t_soft;
    end_sim;
  end
  initial
  begin
    #100000;
    mismatches++;
    end_sim;
  end
endmodule
bind lamsr_top lamsr_chk chk_i (.*);
`default_nettype wire
